// ==== rtl/hsp_consts.vh ====
`ifndef HSP_CONSTS_VH
`define HSP_CONSTS_VH
// Data width of the host port and of the microcontroller bus
`define HSP_DATA_W       8
// Bit of a command byte that clears the host interrupt
`define HSP_CMD_TOP_BIT  7
// FIFO geometry on the memory-to-port path
`define HSP_FIFO_DEPTH   16
`define HSP_FIFO_AW      4
// Status register reset value
`define HSP_STATUS_RST   8'h00
`endif

// ==== rtl/byte_fifo.v ====
`timescale 1ns/1ns
`default_nettype none
// Flop based FIFO, valid/ready on both sides
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             mclk_in,
	input  wire             rst_in,
	input  wire [WIDTH-1:0] wr_data_in,
	input  wire             wr_valid_in,
	output wire             wr_ready_out,
	output wire [WIDTH-1:0] rd_data_out,
	output wire             rd_valid_out,
	input  wire             rd_ready_in
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wptr_reg;
	reg [AW-1:0]    rptr_reg;
	reg [AW:0]      count_reg;
	wire            push;
	wire            pop;

	// ---------------------------------------------------------------
	// Flags
	// ---------------------------------------------------------------
	assign wr_ready_out = (count_reg != DEPTH[AW:0]);
	assign rd_valid_out = (count_reg != {(AW+1){1'b0}});
	assign rd_data_out  = mem_reg[rptr_reg];
	assign push = wr_valid_in & wr_ready_out;
	assign pop  = rd_valid_out & rd_ready_in;

	// Storage has no reset; only pointers and fill count need a defined state
	always @(posedge mclk_in) begin
		if (push) begin
			mem_reg[wptr_reg] <= wr_data_in;
		end
	end

	// Pointers and fill count
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wptr_reg  <= {AW{1'b0}};
			rptr_reg  <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/host_slave_port.v ====
`timescale 1ns/1ns
`default_nettype none
`include "hsp_consts.vh"
module host_slave_port #(
	parameter DW = `HSP_DATA_W
) (
	input  wire          mclk_in,
	input  wire          rst_in,
	// Host side pins; the four input strobes are active low
	input  wire          host_port_select_n_in,
	input  wire          transfer_acknowledge_n_in,
	input  wire          host_rd_n_in,
	input  wire          host_memory_write_strobe_n_in,
	input  wire [DW-1:0] host_data_in,
	output reg  [DW-1:0] host_data_out,
	output wire          host_data_oe_out,
	output wire          transfer_request_out,
	output wire          host_irq_out,
	output wire          illegal_select_out,
	// Microcontroller side, same clock domain
	input  wire          mcu_cmd_rd_in,
	input  wire          mcu_data_rd_in,
	input  wire          mcu_data_wr_in,
	input  wire [DW-1:0] mcu_wdata_in,
	input  wire          mcu_req_arm_in,
	input  wire          mcu_status_wr_in,
	input  wire [DW-1:0] mcu_status_in,
	input  wire          mcu_complete_in,
	output reg  [DW-1:0] mcu_rdata_out,
	output wire          mcu_data_valid_out,
	output wire          mcu_irq_out,
	output wire          host_irq_busy_out
);
	// ---------------------------------------------------------------
	// Synchronisers
	// ---------------------------------------------------------------
	reg  [3:0]    s1_reg;
	reg  [3:0]    s2_reg;
	reg  [3:0]    s3_reg;
	reg  [DW-1:0] d1_reg;
	reg  [DW-1:0] d2_reg;
	wire          sel;
	wire          ack;
	wire          rd;
	wire          wr;
	wire          wr_rise;
	wire          rd_fall;

	// Strobes are asynchronous to mclk_in, two flops before use
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_reg <= 4'hf;
			s2_reg <= 4'hf;
			s3_reg <= 4'hf;
			d1_reg <= {DW{1'b0}};
			d2_reg <= {DW{1'b0}};
		end else begin
			s1_reg <= {host_port_select_n_in, transfer_acknowledge_n_in,
				host_rd_n_in, host_memory_write_strobe_n_in};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			d1_reg <= host_data_in;
			d2_reg <= d1_reg;
		end
	end

	assign sel = ~s2_reg[3];
	assign ack = ~s2_reg[2];
	assign rd  = ~s2_reg[1];
	assign wr  = ~s2_reg[0];
	// Write is taken at its rising (closing) edge, data settled by then
	assign wr_rise = ~s3_reg[0] & s2_reg[0];
	assign rd_fall = s3_reg[1] & ~s2_reg[1];

	// Overlap of select and acknowledge is flagged, not decoded
	assign illegal_select_out = sel & ack;

	// ---------------------------------------------------------------
	// Decoded host cycles
	// ---------------------------------------------------------------
	wire cmd_wr;
	wire dma_wr;
	wire dma_rd;
	assign cmd_wr = wr_rise & sel & ~ack;
	assign dma_wr = wr_rise & ack & ~sel;
	assign dma_rd = rd_fall & ack & ~sel;

	// ---------------------------------------------------------------
	// Command latch, microcontroller interrupt
	// ---------------------------------------------------------------
	reg [DW-1:0] cmd_reg;
	reg          mcu_irq_reg;

	// Set wins over a same-cycle clear so no command is lost
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_reg     <= {DW{1'b0}};
			mcu_irq_reg <= 1'b0;
		end else begin
			if (cmd_wr) begin
				cmd_reg     <= d2_reg;
				mcu_irq_reg <= 1'b1;
			end else if (mcu_cmd_rd_in) begin
				mcu_irq_reg <= 1'b0;
			end
		end
	end
	assign mcu_irq_out = mcu_irq_reg;

	// ---------------------------------------------------------------
	// Data path: memory-to-port bytes buffered in a FIFO
	// ---------------------------------------------------------------
	wire          fifo_in_ready;
	wire [DW-1:0] fifo_out_data;
	wire          fifo_out_valid;

	// A full FIFO withholds the request, which stalls the host DMA
	byte_fifo #(
		.WIDTH (DW),
		.DEPTH (`HSP_FIFO_DEPTH),
		.AW    (`HSP_FIFO_AW)
	) u_fifo (
		.mclk_in      (mclk_in),
		.rst_in       (rst_in),
		.wr_data_in   (d2_reg),
		.wr_valid_in  (dma_wr),
		.wr_ready_out (fifo_in_ready),
		.rd_data_out  (fifo_out_data),
		.rd_valid_out (fifo_out_valid),
		.rd_ready_in  (mcu_data_rd_in)
	);
	assign mcu_data_valid_out = fifo_out_valid;

	// Read data to the microcontroller held in a flop
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mcu_rdata_out <= {DW{1'b0}};
		end else if (mcu_cmd_rd_in) begin
			mcu_rdata_out <= cmd_reg;
		end else if (mcu_data_rd_in & fifo_out_valid) begin
			mcu_rdata_out <= fifo_out_data;
		end
	end

	// ---------------------------------------------------------------
	// Transfer request
	// ---------------------------------------------------------------
	reg          req_reg;
	reg [DW-1:0] out_latch_reg;

	// Armed only by firmware: on a byte load, or for parametric commands
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			req_reg       <= 1'b0;
			out_latch_reg <= {DW{1'b0}};
		end else begin
			if (mcu_data_wr_in) begin
				out_latch_reg <= mcu_wdata_in;
			end
			if (mcu_data_wr_in) begin
				req_reg <= 1'b1;
			end else if (mcu_req_arm_in &
				(mcu_cmd_rd_in | mcu_data_rd_in)) begin
				req_reg <= 1'b1;
			end else if (dma_wr | dma_rd) begin
				req_reg <= 1'b0;
			end
		end
	end
	// One byte per request, held off while the buffer is full
	assign transfer_request_out = req_reg & fifo_in_ready;

	// ---------------------------------------------------------------
	// Status and host interrupt
	// ---------------------------------------------------------------
	reg [DW-1:0] status_reg;
	reg          host_irq_reg;

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			status_reg   <= `HSP_STATUS_RST;
			host_irq_reg <= 1'b0;
		end else begin
			if (mcu_status_wr_in) begin
				status_reg <= mcu_status_in;
			end
			// Completion after status update; only while low
			if (mcu_complete_in & ~host_irq_reg) begin
				host_irq_reg <= 1'b1;
			end else if (cmd_wr & d2_reg[`HSP_CMD_TOP_BIT]) begin
				host_irq_reg <= 1'b0;
			end
		end
	end
	assign host_irq_out      = host_irq_reg;
	assign host_irq_busy_out = host_irq_reg;

	// ---------------------------------------------------------------
	// Host read data: status on select, latch on acknowledge
	// ---------------------------------------------------------------
	// Pins drive only while the host read strobe is seen low
	assign host_data_oe_out = rd & (sel ^ ack);
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			host_data_out <= {DW{1'b0}};
		end else if (sel & ~ack) begin
			host_data_out <= status_reg;
		end else begin
			host_data_out <= out_latch_reg;
		end
	end
endmodule
`default_nettype wire

// ==== tb/hsp_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Port checks
// ------------------------------
module hsp_checker (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic host_port_select_n_in,
	input wire logic transfer_acknowledge_n_in,
	input wire logic host_rd_n_in,
	input wire logic host_memory_write_strobe_n_in,
	input wire logic host_data_oe_out,
	input wire logic transfer_request_out,
	input wire logic host_irq_out,
	input wire logic illegal_select_out,
	input wire logic mcu_cmd_rd_in,
	input wire logic mcu_data_wr_in,
	input wire logic mcu_complete_in,
	input wire logic mcu_data_valid_out,
	input wire logic mcu_irq_out
);
	// Strobes as active high, for shorter properties
	wire s = !host_port_select_n_in;
	wire k = !transfer_acknowledge_n_in;
	wire r = !host_rd_n_in;
	wire w = !host_memory_write_strobe_n_in;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	illegal_flag_a: assert property ((s && k)[*5] |-> illegal_select_out)
		else $error("select with ack not flagged");
	oe_idle_a: assert property ((!r)[*4] |-> !host_data_oe_out)
		else $error("bus driven without read");
	oe_dma_a: assert property ((k && r && !s)[*5] |-> host_data_oe_out)
		else $error("acked read not driven");
	cmd_irq_a: assert property ($fell(w) && s && !k |-> ##[1:6] mcu_irq_out)
		else $error("command gave no irq");
	cmd_clear_a: assert property ((!w)[*6] ##0 mcu_cmd_rd_in |=> !mcu_irq_out)
		else $error("irq kept after command read");
	req_on_wr_a: assert property (
		mcu_data_wr_in && !mcu_data_valid_out |=> transfer_request_out)
		else $error("no request after byte load");
	irq_raise_a: assert property (
		mcu_complete_in && !host_irq_out |=> host_irq_out)
		else $error("completion gave no host irq");
	irq_hold_a: assert property ((!w)[*7] ##0 host_irq_out |=> host_irq_out)
		else $error("host irq fell with no command");
	cmd_seen_c: cover property ($rose(mcu_irq_out));
	dma_in_c: cover property (k && w);
	irq_clear_c: cover property ($fell(host_irq_out));
endmodule
bind host_slave_port hsp_checker hsp_checker_i (.*);
`default_nettype wire

// ==== tb/host_dma_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Host with DMA, 8-bit, no address
// ------------------------------
module host_dma_model (
	input  wire logic       mclk_in,
	input  wire logic       req_in,
	input  wire logic [7:0] port_data_in,
	output var  logic [3:0] pins_out,
	output var  logic [7:0] data_out
);
	// Pins are {select, ack, read, write}, all active low
	initial begin
		pins_out = 4'hf;
		data_out = 8'h00;
	end
	// Hold a pin state n falling edges; strobes never shorter than 3
	task automatic phase(input logic [3:0] p, input int n);
		pins_out = p;
		repeat (n) @(negedge mclk_in);
	endtask
	// Select or ack, byte, then write pulse
	task automatic put(input logic [1:0] sa, input logic [7:0] d);
		data_out = d;
		phase({sa, 2'b11}, 1);
		phase({sa, 2'b10}, 4);
		phase({sa, 2'b11}, 3); // Byte held past the sync delay
		data_out = ~d; // Released bus shows no stale byte
		phase(4'hf, 3);
	endtask
	// Slow host: request polled like an interrupt, byte moved by program
	task automatic serve(input logic [7:0] d);
		wait (req_in === 1'b1);
		@(negedge mclk_in);
		put(2'b10, d);
	endtask
	// Status read by select, DMA read by ack
	task automatic get(input logic [1:0] sa, output logic [7:0] d);
		phase({sa, 2'b11}, 1);
		phase({sa, 2'b01}, 5);
		d = port_data_in;
		phase(4'hf, 3);
	endtask
endmodule
`default_nettype wire

// ==== tb/host_slave_port_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Bench
// ------------------------------
module host_slave_port_bench;
	logic       mclk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic [4:0] pls = 5'h00;
	logic       mcu_req_arm_in = 1'b0;
	logic [7:0] mcu_wdata_in = 8'h00;
	logic [7:0] got;
	int         bad_count = 0;
	int         cmp_count = 0;
	int         cyc = 0;
	wire  [7:0] host_data_in, host_data_out, mcu_rdata_out, mcu_status_in;
	wire        host_port_select_n_in, transfer_acknowledge_n_in;
	wire        host_rd_n_in, host_memory_write_strobe_n_in, host_data_oe_out;
	wire        transfer_request_out, host_irq_out, illegal_select_out;
	wire        mcu_data_valid_out, mcu_irq_out, host_irq_busy_out;
	wire        mcu_cmd_rd_in, mcu_data_rd_in, mcu_data_wr_in;
	wire        mcu_status_wr_in, mcu_complete_in;
	assign {mcu_complete_in, mcu_status_wr_in, mcu_data_wr_in} = pls[4:2];
	assign {mcu_data_rd_in, mcu_cmd_rd_in} = pls[1:0];
	assign mcu_status_in = mcu_wdata_in;
	always #2 mclk_in = ~mclk_in;
	host_slave_port host_slave_port_i (.*);
	host_dma_model host_dma_model_i (.mclk_in(mclk_in),
		.req_in(transfer_request_out),
		.port_data_in(host_data_out), .data_out(host_data_in),
		.pins_out({host_port_select_n_in, transfer_acknowledge_n_in,
			host_rd_n_in, host_memory_write_strobe_n_in}));
	task automatic check(input logic [7:0] seen, exp, input string m);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	// One-cycle microcontroller strobe, answer settled on return
	task automatic pulse(input logic [4:0] p);
		@(negedge mclk_in);
		pls = p;
		@(negedge mclk_in);
		pls = 5'h00;
		repeat (2) @(negedge mclk_in);
	endtask
	task automatic conclude;
		$display("Mismatches %0d of %0d checks", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard, far above the run's length
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic t_cmd;
		host_dma_model_i.put(2'b01, 8'h05);
		check(mcu_irq_out, 1'b1, "command irq");
		pulse(5'h01);
		check(mcu_rdata_out, 8'h05, "command byte");
		check(mcu_irq_out, 1'b0, "irq after read");
		check(transfer_request_out, 1'b0, "request unarmed");
	endtask
	// Fill the FIFO until the request is withheld, then drain it
	task automatic t_fill;
		mcu_req_arm_in = 1'b1;
		for (int i = 0; i < 17; i++) begin
			pulse(5'h01);
			check(transfer_request_out, i < 16, "request");
			if (i < 16) begin
				host_dma_model_i.put(2'b10, 8'h40 + i[7:0]);
				check(transfer_request_out, 1'b0, "one byte");
			end
		end
		mcu_req_arm_in = 1'b0;
		for (int i = 0; i < 16; i++) begin
			pulse(5'h02);
			check(mcu_rdata_out, 8'h40 + i[7:0], "fifo byte");
		end
		check(mcu_data_valid_out, 1'b0, "fifo empty");
	endtask
	task automatic t_out;
		mcu_wdata_in = 8'ha5;
		pulse(5'h04);
		check(transfer_request_out, 1'b1, "out request");
		host_dma_model_i.get(2'b10, got);
		check(got, 8'ha5, "out byte");
		check(transfer_request_out, 1'b0, "request cleared");
	endtask
	// Length-prefixed block, each byte sent only when requested
	task automatic t_block;
		logic [7:0] b;
		mcu_req_arm_in = 1'b1;
		pulse(5'h01);
		for (int i = 0; i < 4; i++) begin
			b = (i == 0) ? 8'h03 : 8'h60 + i[7:0];
			host_dma_model_i.serve(b);
			mcu_req_arm_in = (i < 3);
			pulse(5'h02);
			check(mcu_rdata_out, b, "block byte");
			check(transfer_request_out, i < 3, "rearm");
		end
	endtask
	task automatic t_irq;
		mcu_wdata_in = 8'h3c;
		pulse(5'h08);
		pulse(5'h10);
		check(host_irq_out, 1'b1, "completion irq");
		check(host_irq_busy_out, 1'b1, "busy mirror");
		host_dma_model_i.get(2'b01, got);
		check(got, 8'h3c, "status");
		host_dma_model_i.put(2'b01, 8'h01);
		check(host_irq_out, 1'b1, "irq held");
		host_dma_model_i.put(2'b01, 8'h81);
		check(host_irq_out, 1'b0, "irq cleared");
		check(host_irq_busy_out, 1'b0, "busy cleared");
		pulse(5'h01);
	endtask
	// Select and ack together: flagged, write ignored
	task automatic t_illegal;
		host_dma_model_i.phase(4'h2, 4);
		host_dma_model_i.phase(4'h3, 4);
		check(illegal_select_out, 1'b1, "illegal flag");
		host_dma_model_i.phase(4'hf, 4);
		check({mcu_irq_out, mcu_data_valid_out}, 2'b00, "ignored");
	endtask
	initial begin
		repeat (12) @(negedge mclk_in);
		rst_in = 1'b0;
		repeat (3) @(negedge mclk_in);
		check({host_irq_out, transfer_request_out}, 2'b00, "reset");
		t_cmd();
		// Fill leaves a request pending, so it runs after these two
		t_out();
		t_block();
		t_fill();
		t_irq();
		t_illegal();
		conclude();
	end
endmodule
`default_nettype wire
